/* File: dcp_defs.svh */
`ifndef DCP_DEFS_SVH
`define DCP_DEFS_SVH
// Summary of operation
// [RQ1] prescaler divides by reload value plus one
// [RQ2] one prescaler, one counter for both
// [RQ3] counter runs 0 to 254, wraps
// [RQ4] duty above counter drives output low
// [RQ5] duty at or below counter: output high
// [RQ6] zero constant high, all ones constant low
// [RQ7] prescaler clocked at half oscillator rate
// [RQ8] duty writes take effect immediately
// [RQ9] reload readable, running count hidden
// [RQ10] idle resets channels, outputs high
// [RQ11] expiry reloads prescaler, counter advances one
`define DCP_OFF_DUTY_A 12'h0FC
`define DCP_OFF_DUTY_B 12'h0FD
`define DCP_OFF_RELOAD 12'h0FE
`define DCP_ADDR_W 12
`define DCP_CNT_LAST 8'hFE
`define DCP_ZERO8 8'h00
`define DCP_ZERO32 32'h0000_0000
`endif

/* File: dcp_pkg.sv */
`include "dcp_defs.svh"
package dcp_pkg;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } dcp_apb_req_s;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } dcp_apb_rsp_s;
endpackage

/* File: dcp_timebase.sv */
`include "dcp_defs.svh"
module dcp_timebase (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic idle,
  input wire logic [7:0] reload,
  output logic [7:0] count,
  output logic step
);
  import dcp_pkg::*;
  typedef struct packed {
    logic half;
    logic [7:0] pre;
    logic [7:0] cnt;
    logic step;
  } dcp_tb_s;
  dcp_tb_s st, next_st;
  always_comb begin
    next_st = st;
    next_st.step = 1'b0;
    if (idle) begin
      next_st = '0; // RQ10
    end else begin
      next_st.half = ~st.half; // RQ7
      if (st.half) begin
        if (st.pre == `DCP_ZERO8) begin
          next_st.pre = reload; // RQ1 RQ11
          next_st.step = 1'b1;
          next_st.cnt = (st.cnt == `DCP_CNT_LAST) ? `DCP_ZERO8 : st.cnt + 8'h01; // RQ3
        end else begin
          next_st.pre = st.pre - 8'h01; // RQ1
        end
      end
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign count = st.cnt;
  assign step = st.step;
  property p_wrap;
    @(posedge clk) disable iff (!rst_b) st.cnt <= `DCP_CNT_LAST;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter exceeded 254"); // RQ3
  property p_adv;
    @(posedge clk) disable iff (!rst_b)
    !idle && st.half && st.pre == `DCP_ZERO8 && st.cnt != `DCP_CNT_LAST
      |=> st.cnt == $past(st.cnt) + 8'h01;
  endproperty
  a_adv: assert property (p_adv) else $error("counter did not advance"); // RQ11
endmodule

/* File: dcp_compare.sv */
module dcp_compare #(
  parameter int W = 8
) (
  input wire logic [W-1:0] duty,
  input wire logic [W-1:0] count,
  output logic out_b
);
  assign out_b = !(duty > count); // RQ4 RQ5 RQ6
endmodule

/* File: dcp_pwm.sv */
// The APB interface to the registers was chosen for this implementation.
`include "dcp_defs.svh"
module dcp_pwm (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic idle,
  input wire dcp_pkg::dcp_apb_req_s apb_req,
  output dcp_pkg::dcp_apb_rsp_s apb_rsp,
  output logic [1:0] channel_output_n_b
);
  import dcp_pkg::*;
  // ************************************************
  // state
  // ************************************************
  typedef struct packed {
    logic [7:0] duty_compare_a;
    logic [7:0] duty_compare_b;
    logic [7:0] prescaler_reload;
    dcp_apb_rsp_s rsp;
    logic [1:0] outs;
  } dcp_state_s;
  dcp_state_s st, next_st;
  logic [7:0] count;
  logic step;
  logic [1:0] cmp_b;
  logic [7:0] duty [2];
  logic wr, rd;
  logic [`DCP_ADDR_W-1:0] word;
  assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign rd = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
  // byte offsets are not word aligned: treat as word index
  assign word = apb_req.paddr >> 2;
  // shared timebase for both channels
  dcp_timebase u_tb ( // RQ2
    .clk(clk),
    .rst_b(rst_b),
    .idle(idle),
    .reload(st.prescaler_reload),
    .count(count),
    .step(step)
  );
  assign duty[0] = st.duty_compare_a;
  assign duty[1] = st.duty_compare_b;
  generate
    for (genvar i = 0; i < 2; i++) begin : g_ch
      dcp_compare #(.W(8)) u_cmp (
        .duty(duty[i]),
        .count(count),
        .out_b(cmp_b[i])
      );
    end
  endgenerate
  // ************************************************
  // registers and outputs
  // ************************************************
  always_comb begin
    next_st = st;
    next_st.rsp.pready = 1'b0;
    next_st.rsp.pslverr = 1'b0;
    if (apb_req.psel && !apb_req.penable) begin
      next_st.rsp.pready = 1'b1;
      next_st.rsp.prdata = `DCP_ZERO32;
      if (rd) begin
        unique case (word)
          `DCP_OFF_DUTY_A: next_st.rsp.prdata = {24'h0, st.duty_compare_a};
          `DCP_OFF_DUTY_B: next_st.rsp.prdata = {24'h0, st.duty_compare_b};
          `DCP_OFF_RELOAD: next_st.rsp.prdata = {24'h0, st.prescaler_reload}; // RQ9
          default: next_st.rsp.pslverr = 1'b1;
        endcase
      end else if (!(word == `DCP_OFF_DUTY_A || word == `DCP_OFF_DUTY_B ||
                     word == `DCP_OFF_RELOAD)) begin
        next_st.rsp.pslverr = 1'b1;
      end
    end
    if (wr && st.rsp.pready) begin
      unique case (word)
        `DCP_OFF_DUTY_A: next_st.duty_compare_a = apb_req.pwdata[7:0]; // RQ8
        `DCP_OFF_DUTY_B: next_st.duty_compare_b = apb_req.pwdata[7:0]; // RQ8
        `DCP_OFF_RELOAD: next_st.prescaler_reload = apb_req.pwdata[7:0];
        default: ;
      endcase
    end
    next_st.outs = idle ? 2'b11 : cmp_b; // RQ10 RQ4 RQ5
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
      st.outs <= 2'b11;
    end else begin
      st <= next_st;
    end
  end
  assign apb_rsp = st.rsp;
  assign channel_output_n_b = st.outs;
  // ************************************************
  // checks
  // ************************************************
  property p_idle_high;
    @(posedge clk) disable iff (!rst_b) idle |=> channel_output_n_b == 2'b11;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("idle output not high"); // RQ10
  property p_zero_high;
    @(posedge clk) disable iff (!rst_b) !idle && st.duty_compare_a == 8'h00 |=> channel_output_n_b[0];
  endproperty
  a_zero_high: assert property (p_zero_high) else $error("zero duty not high"); // RQ6
  property p_ff_low;
    @(posedge clk) disable iff (!rst_b) !idle && st.duty_compare_b == 8'hFF |=> !channel_output_n_b[1];
  endproperty
  a_ff_low: assert property (p_ff_low) else $error("full duty not low"); // RQ6
  property p_cmp_a;
    @(posedge clk) disable iff (!rst_b) !idle |=> channel_output_n_b[0] == !($past(st.duty_compare_a) > $past(count));
  endproperty
  a_cmp_a: assert property (p_cmp_a) else $error("channel a compare wrong"); // RQ4
  property p_cmp_b;
    @(posedge clk) disable iff (!rst_b) !idle |=> channel_output_n_b[1] == !($past(st.duty_compare_b) > $past(count));
  endproperty
  a_cmp_b: assert property (p_cmp_b) else $error("channel b compare wrong"); // RQ5
  property p_wr_now;
    @(posedge clk) disable iff (!rst_b) wr && st.rsp.pready && word == `DCP_OFF_DUTY_A |=> st.duty_compare_a == $past(apb_req.pwdata[7:0]);
  endproperty
  a_wr_now: assert property (p_wr_now) else $error("duty write not applied"); // RQ8
  property p_rd_reload;
    @(posedge clk) disable iff (!rst_b) rd && word == `DCP_OFF_RELOAD |=> apb_rsp.prdata[7:0] == st.prescaler_reload;
  endproperty
  a_rd_reload: assert property (p_rd_reload) else $error("reload readback wrong"); // RQ9
  property p_step_spacing;
    @(posedge clk) disable iff (!rst_b) step && !idle && st.prescaler_reload == 8'h00 |-> ##[1:4] (step || idle);
  endproperty
  a_step_spacing: assert property (p_step_spacing) else $error("step spacing wrong"); // RQ7
  c_wrap: cover property (@(posedge clk) disable iff (!rst_b) step && count == 8'h00);
  c_wr: cover property (@(posedge clk) disable iff (!rst_b) wr && st.rsp.pready);
  c_idle: cover property (@(posedge clk) disable iff (!rst_b) idle);
  c_err: cover property (@(posedge clk) disable iff (!rst_b) apb_rsp.pslverr);
  c_full: cover property (@(posedge clk) disable iff (!rst_b) st.duty_compare_b == 8'hFF);

  // ************************************************
  // bus checks
  // ************************************************
  // decode hit, kept apart from the logic so a decode slip shows here
  logic hit;
  assign hit = word == `DCP_OFF_DUTY_A || word == `DCP_OFF_DUTY_B ||
               word == `DCP_OFF_RELOAD;

  property p_ready_pulse;
    @(posedge clk) disable iff (!rst_b)
    apb_rsp.pready |=> !apb_rsp.pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready longer than one cycle");

  property p_ready_after_setup;
    @(posedge clk) disable iff (!rst_b)
    apb_req.psel && !apb_req.penable |=> apb_rsp.pready;
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup)
    else $error("no ready in access phase");

  property p_no_ready_unsel;
    @(posedge clk) disable iff (!rst_b)
    !apb_req.psel |=> !apb_rsp.pready;
  endproperty
  a_no_ready_unsel: assert property (p_no_ready_unsel)
    else $error("ready without select");

  property p_err_unmapped;
    @(posedge clk) disable iff (!rst_b)
    apb_req.psel && !apb_req.penable && !hit |=> apb_rsp.pslverr;
  endproperty
  a_err_unmapped: assert property (p_err_unmapped)
    else $error("unmapped access not refused");

  property p_no_err_mapped;
    @(posedge clk) disable iff (!rst_b)
    apb_req.psel && !apb_req.penable && hit |=> !apb_rsp.pslverr;
  endproperty
  a_no_err_mapped: assert property (p_no_err_mapped)
    else $error("mapped access refused");

  property p_err_with_ready;
    @(posedge clk) disable iff (!rst_b)
    apb_rsp.pslverr |-> apb_rsp.pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready)
    else $error("error without ready");

  property p_upper_zero;
    @(posedge clk) disable iff (!rst_b)
    apb_rsp.pready |-> apb_rsp.prdata[31:8] == 24'h000000;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper read bits not zero");

  property p_rd_a;
    @(posedge clk) disable iff (!rst_b)
    rd && word == `DCP_OFF_DUTY_A |=> apb_rsp.prdata[7:0] == $past(st.duty_compare_a);
  endproperty
  a_rd_a: assert property (p_rd_a)
    else $error("duty a readback wrong");

  property p_rd_b;
    @(posedge clk) disable iff (!rst_b)
    rd && word == `DCP_OFF_DUTY_B |=> apb_rsp.prdata[7:0] == $past(st.duty_compare_b);
  endproperty
  a_rd_b: assert property (p_rd_b)
    else $error("duty b readback wrong");

  property p_rd_unmapped;
    @(posedge clk) disable iff (!rst_b)
    rd && !hit |=> apb_rsp.prdata == `DCP_ZERO32;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped)
    else $error("unmapped read not zero");

  property p_wr_b_now;
    @(posedge clk) disable iff (!rst_b)
    wr && st.rsp.pready && word == `DCP_OFF_DUTY_B
      |=> st.duty_compare_b == $past(apb_req.pwdata[7:0]);
  endproperty
  a_wr_b_now: assert property (p_wr_b_now) // RQ8
    else $error("duty b write not applied");

  property p_wr_reload;
    @(posedge clk) disable iff (!rst_b)
    wr && st.rsp.pready && word == `DCP_OFF_RELOAD
      |=> st.prescaler_reload == $past(apb_req.pwdata[7:0]);
  endproperty
  a_wr_reload: assert property (p_wr_reload) // RQ9
    else $error("reload write not applied");

  property p_wr_unmapped;
    @(posedge clk) disable iff (!rst_b)
    wr && st.rsp.pready && !hit |=> $stable(st.duty_compare_a) &&
      $stable(st.duty_compare_b) && $stable(st.prescaler_reload);
  endproperty
  a_wr_unmapped: assert property (p_wr_unmapped)
    else $error("unmapped write changed a register");

  property p_no_wr_hold;
    @(posedge clk) disable iff (!rst_b)
    !(wr && st.rsp.pready) |=> $stable(st.duty_compare_a) &&
      $stable(st.duty_compare_b) && $stable(st.prescaler_reload);
  endproperty
  a_no_wr_hold: assert property (p_no_wr_hold)
    else $error("register changed without write");

  // ************************************************
  // timebase checks
  // ************************************************
  property p_idle_count;
    @(posedge clk) disable iff (!rst_b)
    idle |=> count == `DCP_ZERO8;
  endproperty
  a_idle_count: assert property (p_idle_count) // RQ10
    else $error("idle did not clear counter");

  property p_idle_no_step;
    @(posedge clk) disable iff (!rst_b)
    idle |=> !step;
  endproperty
  a_idle_no_step: assert property (p_idle_no_step) // RQ10
    else $error("step during idle");

  property p_count_range;
    @(posedge clk) disable iff (!rst_b)
    count <= `DCP_CNT_LAST;
  endproperty
  a_count_range: assert property (p_count_range) // RQ3
    else $error("counter above 254");

  property p_step_advance;
    @(posedge clk) disable iff (!rst_b)
    step |-> count == $past(count) + 8'h01 ||
      count == `DCP_ZERO8 && $past(count) == `DCP_CNT_LAST;
  endproperty
  a_step_advance: assert property (p_step_advance) // RQ11
    else $error("step did not advance counter by one");

  property p_count_hold;
    @(posedge clk) disable iff (!rst_b)
    !step && !$past(idle) |-> $stable(count);
  endproperty
  a_count_hold: assert property (p_count_hold) // RQ11
    else $error("counter moved without step");

  property p_step_gap;
    @(posedge clk) disable iff (!rst_b)
    step |=> !step;
  endproperty
  a_step_gap: assert property (p_step_gap) // RQ7
    else $error("steps closer than two clocks");

  property p_wrap_zero;
    @(posedge clk) disable iff (!rst_b)
    step && $past(count) == `DCP_CNT_LAST |-> count == `DCP_ZERO8;
  endproperty
  a_wrap_zero: assert property (p_wrap_zero) // RQ3
    else $error("counter did not wrap to zero");

  // ************************************************
  // output checks
  // ************************************************
  property p_ff_low_a;
    @(posedge clk) disable iff (!rst_b)
    !idle && st.duty_compare_a == 8'hFF |=> !channel_output_n_b[0];
  endproperty
  a_ff_low_a: assert property (p_ff_low_a) // RQ6
    else $error("full duty a not low");

  property p_zero_high_b;
    @(posedge clk) disable iff (!rst_b)
    st.duty_compare_b == `DCP_ZERO8 |=> channel_output_n_b[1];
  endproperty
  a_zero_high_b: assert property (p_zero_high_b) // RQ6
    else $error("zero duty b not high");
endmodule

/* File: dcp_load.sv */
module dcp_load (
  input wire logic clk,
  input wire logic clr,
  input wire logic [1:0] pin_b,
  output logic [15:0] low_a,
  output logic [15:0] low_b
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // integrating load: low time per channel
  // ****
  always_ff @(posedge clk) begin
    low_a <= clr ? 16'h0000 : low_a + {15'h0000, ~pin_b[0]};
    low_b <= clr ? 16'h0000 : low_b + {15'h0000, ~pin_b[1]};
  end
endmodule

/* File: tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dcp_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic idle = 1'b0;
  logic clr = 1'b0;
  dcp_apb_req_s req = '0;
  dcp_apb_rsp_s rsp;
  logic [1:0] pin_b;
  logic [15:0] low_a, low_b;
  logic [31:0] q;
  logic e;
  int mismatches = 0;
  int n_tests = 0;
  logic [11:0] adr [4] = '{12'h3F0, 12'h3F4, 12'h3F8, 12'h3FC};
  logic [7:0] tbl [3][3] = '{'{8'h00, 8'h40, 8'hFF}, '{8'h01, 8'h00, 8'h80}, '{8'h02, 8'h01, 8'hFE}};
  always #12.5 clk = ~clk;
  dcp_pwm dut (.clk(clk), .rst_b(rst_b), .idle(idle), .apb_req(req), .apb_rsp(rsp),
    .channel_output_n_b(pin_b));
  dcp_load load (.clk(clk), .clr(clr), .pin_b(pin_b), .low_a(low_a), .low_b(low_b));
  // ****
  // tasks
  // ****
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // values read right after the edge are the sampled ones
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    q = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
    if (n >= 20) begin
      mismatches++;
      tally_and_finish();
    end
  endtask
  initial begin
    int per;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, adr[i], 32'h0000_0000);
      check(q, 32'h0000_0000);
      check({31'h0, e}, {31'h0, i == 3});
    end
    apb(1'b1, adr[2], 32'h0000_00A5);
    apb(1'b0, adr[2], 32'h0000_0000);
    check(q, 32'h0000_00A5);
    apb(1'b1, adr[3], 32'h0000_0012);
    check({31'h0, e}, 32'h0000_0001);
    apb(1'b0, adr[3], 32'h0000_0000);
    check(q, 32'h0000_0000);
    $display("test regs done");
    // low time over one period is 2*(reload+1)*duty, also for FF
    for (int t = 0; t < 3; t++) begin
      for (int k = 0; k < 3; k++) begin
        apb(1'b1, adr[(k + 2) % 3], {24'h000000, tbl[t][k]});
      end
      per = 510 * (tbl[t][0] + 1);
      repeat (per + 20) @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (per + 1) @(posedge clk);
      check({16'h0000, low_a}, 32'(2 * (tbl[t][0] + 1) * tbl[t][1]));
      check({16'h0000, low_b}, 32'(2 * (tbl[t][0] + 1) * tbl[t][2]));
      $display("test pwm %0d done", t);
    end
    apb(1'b1, adr[0], 32'h0000_0000);
    repeat (2) @(posedge clk);
    check({31'h0, pin_b[0]}, 32'h0000_0001);
    apb(1'b1, adr[0], 32'h0000_00FF);
    repeat (2) @(posedge clk);
    check({31'h0, pin_b[0]}, 32'h0000_0000);
    idle <= 1'b1;
    repeat (3) @(posedge clk);
    check({30'h0, pin_b}, 32'h0000_0003);
    idle <= 1'b0;
    apb(1'b0, adr[2], 32'h0000_0000);
    check(q, 32'h0000_0002);
    $display("test idle done");
    tally_and_finish();
  end
endmodule
